// [hdl/ssm_top.sv]
// standstill and overspeed monitor with classic wishbone registers
// Behaviour
// R1: zero flag is 1 below the zero-speed limit, 0 above it.
// R2: overspeed output is 0 above the selected threshold, 1 below it.
// R3: the opposite polarity is offered by a control bit, default as R2.
// R4: direction output is 1 counterclockwise, 0 clockwise, when enabled.
// R5: direction output exists only when an encoder is configured.
// R6: bidirectional setting detects excess in both rotation directions.
// R7: single-direction setting detects excess only in the chosen direction; without an encoder the code detects both directions.
// R8: one to eight thresholds; legacy mode caps them at four.
// R9: with several thresholds, select inputs choose the active one.
// R10: select bits form a binary index, bit0 least significant.
// R11: hysteresis is a percentage of the threshold filtering small changes.
// R12: lower frequency is the threshold reduced by the hysteresis.
// R13: rotary axis: frequency is rpm over 60 times pulses per revolution.
// R14: linear axis, rotary sensor: m/min times 1000 over 60 pitch, times ppr.
// R15: linear sensor: mm/s times 1000 over micrometres per pulse.
// R16: second sensor is scaled by the gear ratio, 1 on the same part.
// R17: five sensor sets: enc, prox, enc+prox, prox+prox, enc+enc.
// R18: sin/cos sum check, or a simplified plausibility check when disabled.
// R19: each sensor has its own resolution.
// R20: proximity input handles PNP/NPN, NO/NC sensors.
// R21: flags re-evaluated every cycle; release needs crossing the lower frequency.
`timescale 1ns/100ps
`default_nettype none
module ssm_top
	import ssm_pkg::*;
#(
	parameter int unsigned GATE_CYCLES_P = ssm_pkg::GATE_CYCLES
)(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [ssm_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     enc1_a_i,
	input  wire logic                     enc1_b_i,
	input  wire logic                     enc2_a_i,
	input  wire logic                     enc2_b_i,
	input  wire logic                     prox1_i,
	input  wire logic                     prox2_i,
	input  wire logic                     threshold_select_bit0_i,
	input  wire logic                     threshold_select_bit1_i,
	input  wire logic                     threshold_select_bit2_i,
	input  wire logic                     sincos_sum_ok_i,
	output logic                          zero_o,
	output logic                          over_o,
	output logic                          dir_o,
	output logic                          mismatch_o,
	output logic                          plaus_err_o
);
	import ssm_pkg::*;

	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[8*b +: 8] = nw[8*b +: 8];
		end
		merge_sel = res;
	endfunction : merge_sel

	function automatic logic [FREQ_W-1:0] lower_freq(input logic [FREQ_W-1:0] f,
		input logic [HYST_W-1:0] pct);
		logic [HYST_W-1:0]        p;
		logic [FREQ_W+HYST_W-1:0] prod;
		p = (pct > HYST_MAX) ? HYST_MAX : pct;
		prod = f * p;
		lower_freq = f - FREQ_W'(prod / PCT_FULL);
	endfunction : lower_freq

	// pin synchronisers, three stages, second and third must agree
	wire  [NPIN-1:0] pins = {sincos_sum_ok_i, threshold_select_bit2_i, threshold_select_bit1_i,
		threshold_select_bit0_i, prox2_i, prox1_i, enc2_b_i, enc2_a_i, enc1_b_i, enc1_a_i};
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic [NPIN-1:0] sync3;
	logic [NPIN-1:0] filt;
	logic [NPIN-1:0] filt_d;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			// sum-ok rests high; a low reset value would latch a false fault
			localparam logic RST_LVL = (gi == PIN_SC);
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					sync1[gi] <= RST_LVL;
					sync2[gi] <= RST_LVL;
					sync3[gi] <= RST_LVL;
					filt[gi]  <= RST_LVL;
				end
				else
				begin
					sync1[gi] <= pins[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
						filt[gi] <= sync3[gi];
				end
			end
		end
	endgenerate

	// registers
	logic [31:0]        ctrl;
	logic [FREQ_W-1:0]  zero_lim;
	logic [31:0]        res_reg;
	logic [RATIO_W-1:0] ratio;
	logic [FREQ_W-1:0]  thr [NUM_THR];
	logic [FREQ_W-1:0]  freq1;
	logic [FREQ_W-1:0]  freq2;
	logic [FREQ_W-1:0]  cnt1;
	logic [FREQ_W-1:0]  cnt2;
	logic [31:0]        gate_cnt;
	logic               exc;
	logic               dir_ccw;

	wire [2:0]        cfg     = ctrl[CTRL_CFG_LSB +: 3];
	wire [1:0]        mode    = ctrl[CTRL_MODE_LSB +: 2];
	wire              dir_en  = ctrl[CTRL_DIR_EN];
	wire              achk_on = !ctrl[CTRL_ACHK_DIS];
	wire              pol_ovw = ctrl[CTRL_POL];
	wire [HYST_W-1:0] hyst    = ctrl[CTRL_HYST_LSB +: HYST_W];
	wire [1:0]        thrn_raw = ctrl[CTRL_THRN_LSB +: 2];
	wire [RES_W-1:0]  res1    = res_reg[RES_W-1:0];
	wire [RES_W-1:0]  res2    = res_reg[31:RES_W];

	// sensor set decode [R17]
	wire has_enc = (cfg == CFG_ENC) || (cfg == CFG_ENC_PROX) || (cfg == CFG_ENC_ENC);
	wire has_two = (cfg == CFG_ENC_PROX) || (cfg == CFG_PROX_PROX) || (cfg == CFG_ENC_ENC);
	// NC or NPN wiring is folded into one inversion bit [R20]
	wire prox_inv = ctrl[CTRL_PROX_INV];
	wire p1_now = filt[PIN_P1] ^ prox_inv;
	wire p1_old = filt_d[PIN_P1] ^ prox_inv;
	wire p2_now = filt[PIN_P2] ^ prox_inv;
	wire p2_old = filt_d[PIN_P2] ^ prox_inv;
	wire e1a_rise = filt[PIN_E1A] & !filt_d[PIN_E1A];
	wire e2a_rise = filt[PIN_E2A] & !filt_d[PIN_E2A];
	wire rise1 = has_enc ? e1a_rise : (p1_now & !p1_old);
	wire rise2 = (cfg == CFG_ENC_ENC) ? e2a_rise :
		(cfg == CFG_ENC_PROX) ? (p1_now & !p1_old) : (p2_now & !p2_old);

	// measuring gate; each gate end is one evaluation cycle [R21]
	wire gate_end = (gate_cnt == GATE_CYCLES_P - 1);
	wire [31:0] next_gate = gate_end ? 32'h0000_0000 : gate_cnt + 32'h0000_0001;
	wire [FREQ_W-1:0] next_cnt1 = (&cnt1) ? cnt1 : cnt1 + FREQ_W'(rise1);
	wire [FREQ_W-1:0] next_cnt2 = (&cnt2) ? cnt2 : cnt2 + FREQ_W'(rise2);

	// threshold index; legacy parts stop at four [R8] [R9] [R10]
	wire [1:0] thrn = (ctrl[CTRL_LEGACY] && thrn_raw > THRN_LEGACY) ? THRN_LEGACY : thrn_raw;
	wire [SEL_W-1:0] sel_mask = SEL_W'((4'h1 << thrn) - 4'h1);
	wire [SEL_W-1:0] sel_idx = {filt[PIN_S2], filt[PIN_S1], filt[PIN_S0]} & sel_mask;

	// thresholds hold frequencies already converted by software [R13] [R14] [R15]
	wire [FREQ_W-1:0] upper_threshold_frequency = thr[sel_idx];
	wire [FREQ_W-1:0] lower_threshold_frequency = lower_freq(upper_threshold_frequency, hyst); // [R11] [R12]
	wire [FREQ_W-1:0] zero_lo = lower_freq(zero_lim, hyst); // [R11] [R12]

	// direction: B high at the A rising edge means counterclockwise
	wire next_ccw = (has_enc && e1a_rise) ? filt[PIN_E1B] : dir_ccw;
	wire dir_ok = (mode == MODE_BIDIR) ? 1'b1 : // [R6]
		!has_enc ? 1'b1 :
		(mode == MODE_CW) ? !dir_ccw : // [R7]
		(mode == MODE_CCW) ? dir_ccw : 1'b1;

	// overspeed latch, released below the lower frequency or in a direction that is not selected [R21]
	wire next_exc = !gate_end ? exc :
		(dir_ok && cnt1 > upper_threshold_frequency) ? 1'b1 :
		(!dir_ok || cnt1 < lower_threshold_frequency) ? 1'b0 : exc;
	// zero flag with the same hysteresis band [R1] [R21]
	wire next_zero = !gate_end ? zero_o :
		(cnt1 > zero_lim) ? 1'b0 :
		(cnt1 < zero_lo) ? 1'b1 : zero_o;
	wire next_over = pol_ovw ? next_exc : !next_exc; // [R2] [R3]
	wire next_dir = dir_en & has_enc & next_ccw; // [R4] [R5]

	// gear-ratio and resolution check: f2*res1 against ratio*f1*res2 [R16] [R19]
	wire [47:0] lhs = 48'(freq2) * 48'(res1);
	wire [47:0] rhs = 48'(freq1) * 48'(res2) * 48'(ratio);
	wire [47:0] gap = (lhs > rhs) ? lhs - rhs : rhs - lhs;
	wire next_mism = has_two && (gap > (rhs >> 3));

	// plausibility; quadrature jumps stand in when the sum check is off [R18]
	wire a_chg = filt[PIN_E1A] ^ filt_d[PIN_E1A];
	wire b_chg = filt[PIN_E1B] ^ filt_d[PIN_E1B];
	wire plaus_set = has_enc && (achk_on ? !filt[PIN_SC] : (a_chg & b_chg));

	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire [5:0] widx = wb_adr_i[ADR_W-1:2];
	wire is_ctrl  = (widx == OFS_CTRL[ADR_W-1:2]);
	wire is_zero  = (widx == OFS_ZERO[ADR_W-1:2]);
	wire is_res   = (widx == OFS_RES[ADR_W-1:2]);
	wire is_ratio = (widx == OFS_RATIO[ADR_W-1:2]);
	wire is_stat  = (widx == OFS_STATUS[ADR_W-1:2]);
	wire is_f1    = (widx == OFS_FREQ1[ADR_W-1:2]);
	wire is_f2    = (widx == OFS_FREQ2[ADR_W-1:2]);
	wire is_thr   = (wb_adr_i[ADR_W-1:5] == OFS_THR[ADR_W-1:5]);
	wire [2:0] thr_w = wb_adr_i[4:2];
	wire plaus_clr = bus_wr && is_stat && wb_sel_i[0] && wb_dat_i[ST_PLAUS];
	wire [31:0] status = {27'h0, plaus_err_o, mismatch_o, dir_ccw, exc, zero_o};
	wire [31:0] rd_mux = is_ctrl ? ctrl :
		is_zero  ? {8'h00, zero_lim} :
		is_res   ? res_reg :
		is_ratio ? {24'h00_0000, ratio} :
		is_stat  ? status :
		is_f1    ? {8'h00, freq1} :
		is_f2    ? {8'h00, freq2} :
		is_thr   ? {8'h00, thr[thr_w]} : 32'h0000_0000;
	wire [31:0] wr_ctrl  = merge_sel(ctrl, wb_dat_i, wb_sel_i);
	wire [31:0] wr_zero  = merge_sel({8'h00, zero_lim}, wb_dat_i, wb_sel_i);
	wire [31:0] wr_res   = merge_sel(res_reg, wb_dat_i, wb_sel_i);
	wire [31:0] wr_ratio = merge_sel({24'h00_0000, ratio}, wb_dat_i, wb_sel_i);
	wire [31:0] wr_thr   = merge_sel({8'h00, thr[thr_w]}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl     <= CTRL_RST;
			zero_lim <= ZERO_RST;
			res_reg  <= RES_RST;
			ratio    <= RATIO_RST;
			for (int i = 0; i < NUM_THR; i++)
				thr[i] <= THR_RST;
		end
		else
		begin
			wb_ack_o <= bus_req;
			if (bus_req)
				wb_dat_o <= rd_mux;
			if (bus_wr && is_ctrl)
				ctrl <= wr_ctrl;
			if (bus_wr && is_zero)
				zero_lim <= wr_zero[FREQ_W-1:0];
			if (bus_wr && is_res)
				res_reg <= wr_res;
			if (bus_wr && is_ratio)
				ratio <= wr_ratio[RATIO_W-1:0];
			if (bus_wr && is_thr)
				thr[thr_w] <= wr_thr[FREQ_W-1:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			filt_d      <= '0;
			gate_cnt    <= 32'h0000_0000;
			cnt1        <= '0;
			cnt2        <= '0;
			freq1       <= '0;
			freq2       <= '0;
			exc         <= 1'b0;
			dir_ccw     <= 1'b0;
			zero_o      <= 1'b0;
			over_o      <= 1'b1;
			dir_o       <= 1'b0;
			mismatch_o  <= 1'b0;
			plaus_err_o <= 1'b0;
		end
		else
		begin
			filt_d   <= filt;
			gate_cnt <= next_gate;
			cnt1     <= gate_end ? FREQ_W'(rise1) : next_cnt1;
			cnt2     <= gate_end ? FREQ_W'(rise2) : next_cnt2;
			if (gate_end)
			begin
				freq1 <= cnt1;
				freq2 <= cnt2;
			end
			exc        <= next_exc;
			dir_ccw    <= next_ccw;
			zero_o     <= next_zero;
			over_o     <= next_over;
			dir_o      <= next_dir;
			mismatch_o <= next_mism;
			// a new fault in the clearing cycle wins over the clear
			plaus_err_o <= plaus_set | (plaus_err_o & !plaus_clr);
		end
	end

	a_zero_above_limit: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(gate_end && cnt1 > zero_lim) |=> !zero_o)
		else $error("zero flag set above limit");
	a_zero_below_lower: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(gate_end && cnt1 < zero_lo && cnt1 <= zero_lim) |=> zero_o)
		else $error("zero flag missing below limit");
	a_over_exceeded: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(gate_end && dir_ok && cnt1 > upper_threshold_frequency && !pol_ovw) |=> !over_o)
		else $error("overspeed output not low above threshold");
	a_over_release: assert property (@(posedge clk_i) disable iff (rst_i) // [R21]
		(gate_end && cnt1 < lower_threshold_frequency && !pol_ovw) |=> over_o)
		else $error("overspeed output not released below lower frequency");
	a_dir_filter: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		(gate_end && has_enc && mode == MODE_CW && dir_ccw) |=> !exc)
		else $error("excess latched in the unselected direction");
	a_dir_absent: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		(!has_enc || !dir_en) |=> !dir_o)
		else $error("direction output without encoder or enable");
	a_legacy_cap: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		ctrl[CTRL_LEGACY] |-> sel_idx < 3'h4)
		else $error("legacy mode selects beyond four thresholds");
	a_single_thr: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		(thrn_raw == 2'h0) |-> (sel_idx == 3'h0))
		else $error("select inputs active with one threshold");
	a_hyst_order: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		lower_threshold_frequency <= upper_threshold_frequency)
		else $error("lower frequency above upper frequency");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle after request");
	a_plaus_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		plaus_set |=> plaus_err_o)
		else $error("plausibility fault not latched");
	a_plaus_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		(plaus_clr && !plaus_set) |=> !plaus_err_o)
		else $error("plausibility fault not cleared by write");
	a_dir_sample: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		(dir_en && has_enc && e1a_rise) |=> (dir_o == $past(filt[PIN_E1B])))
		else $error("direction output differs from b at a rising edge");
	a_mism_single: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		!has_two |=> !mismatch_o)
		else $error("speed mismatch with a single sensor");
endmodule : ssm_top
`default_nettype wire

// [hdl/ssm_pkg.sv]
// constants, register map and field layout of the speed monitor
package ssm_pkg;
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned GATE_TIME_MS = 1000;
	localparam int unsigned GATE_CYCLES  = CLK_HZ / 1000 * GATE_TIME_MS;
	localparam int          FREQ_W       = 24;
	localparam int          RES_W        = 16;
	localparam int          RATIO_W      = 8;
	localparam int          HYST_W       = 7;
	localparam int          NUM_THR      = 8;
	localparam int          SEL_W        = 3;
	localparam int          ADR_W        = 8;
	localparam int          NPIN         = 10;
	localparam logic [HYST_W-1:0] HYST_MAX = 7'h64;
	localparam int unsigned PCT_FULL     = 100;
	// byte offsets
	localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADR_W-1:0] OFS_ZERO   = 8'h04;
	localparam logic [ADR_W-1:0] OFS_RES    = 8'h08;
	localparam logic [ADR_W-1:0] OFS_RATIO  = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADR_W-1:0] OFS_FREQ1  = 8'h14;
	localparam logic [ADR_W-1:0] OFS_FREQ2  = 8'h18;
	localparam logic [ADR_W-1:0] OFS_THR    = 8'h20;
	// control fields
	localparam int CTRL_CFG_LSB  = 0;
	localparam int CTRL_MODE_LSB = 3;
	localparam int CTRL_DIR_EN   = 5;
	localparam int CTRL_ACHK_DIS = 6;
	localparam int CTRL_PROX_INV = 7;
	localparam int CTRL_THRN_LSB = 8;
	localparam int CTRL_LEGACY   = 10;
	localparam int CTRL_POL      = 11;
	localparam int CTRL_HYST_LSB = 12;
	// status bits
	localparam int ST_ZERO  = 0;
	localparam int ST_EXC   = 1;
	localparam int ST_CCW   = 2;
	localparam int ST_MISM  = 3;
	localparam int ST_PLAUS = 4;
	// reset values
	localparam logic [31:0]        CTRL_RST  = 32'h0000_0000;
	localparam logic [FREQ_W-1:0]  ZERO_RST  = 24'h00_0000;
	localparam logic [FREQ_W-1:0]  THR_RST   = 24'hff_ffff;
	localparam logic [31:0]        RES_RST   = 32'h0001_0001;
	localparam logic [RATIO_W-1:0] RATIO_RST = 8'h01;
	// sensor sets
	localparam logic [2:0] CFG_ENC       = 3'h0;
	localparam logic [2:0] CFG_PROX      = 3'h1;
	localparam logic [2:0] CFG_ENC_PROX  = 3'h2;
	localparam logic [2:0] CFG_PROX_PROX = 3'h3;
	localparam logic [2:0] CFG_ENC_ENC   = 3'h4;
	// direction decision
	localparam logic [1:0] MODE_BIDIR = 2'h0;
	localparam logic [1:0] MODE_CW    = 2'h1;
	localparam logic [1:0] MODE_CCW   = 2'h2;
	// legacy limit: log2 of four thresholds
	localparam logic [1:0] THRN_LEGACY = 2'h2;
	// pin positions in the synchroniser vector
	localparam int PIN_E1A = 0;
	localparam int PIN_E1B = 1;
	localparam int PIN_E2A = 2;
	localparam int PIN_E2B = 3;
	localparam int PIN_P1  = 4;
	localparam int PIN_P2  = 5;
	localparam int PIN_S0  = 6;
	localparam int PIN_S1  = 7;
	localparam int PIN_S2  = 8;
	localparam int PIN_SC  = 9;
endpackage : ssm_pkg

// [tb/ssm_sensor_model.sv]
// behavioural quadrature encoder and proximity sensor for the speed monitor bench
`timescale 1ns/100ps
`default_nettype none
module ssm_sensor_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] quarter_i,
	input  wire logic       ccw_i,
	input  wire logic       jump_i,
	output logic            enc_a_o,
	output logic            enc_b_o,
	output logic            prox_o
);
	logic [7:0] cnt;
	logic [1:0] ph;
	// quarter_i is clocks per quadrature step, zero holds the axis still
	wire        step = (quarter_i != 8'h00) && (cnt + 8'h01 >= quarter_i);
	always_ff @(posedge clk_i)
	begin
		if (rst_i || step)
			cnt <= 8'h00;
		else if (quarter_i != 8'h00)
			cnt <= cnt + 8'h01;
		if (rst_i)
			ph <= 2'h0;
		else if (step)
			// jump_i moves a and b in one clock to trip the simple
			ph <= jump_i ? ph + 2'h2 : ccw_i ? ph + 2'h1 : ph - 2'h1; // ccw: b leads a
	end
	// without jump_i a and b never move in one clock, so the simple check stays quiet
	assign enc_a_o = ph[1];
	assign enc_b_o = ph[1] ^ ph[0];
	// pnp normally open proximity, one pulse per encoder period
	assign prox_o  = ph[1];
endmodule : ssm_sensor_model
`default_nettype wire

// [tb/ssm_top_tb.sv]
// self-checking bench for the standstill and overspeed monitor
`timescale 1ns/100ps
`default_nettype none
module ssm_top_tb;
	import ssm_pkg::*;
	// short gate: 200 clocks, so counts are rising edges per 200 clocks
	localparam int unsigned GATE = 200;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack;
	logic [2:0]  tsel = 3'h0;
	logic        sc_ok = 1'b1;
	logic [7:0]  quarter = 8'h00;
	logic        ccw = 1'b0;
	logic        jump = 1'b0;
	logic        ea, eb, px, zero, over, dir, mism, plaus;
	int          err_count = 0;
	int          num_checks = 0;
	always #12.5 clk_i = ~clk_i;
	ssm_top #(.GATE_CYCLES_P(GATE)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.enc1_a_i(ea), .enc1_b_i(eb), .enc2_a_i(ea), .enc2_b_i(eb), .prox1_i(px),
		.prox2_i(px), .threshold_select_bit0_i(tsel[0]), .threshold_select_bit1_i(tsel[1]),
		.threshold_select_bit2_i(tsel[2]), .sincos_sum_ok_i(sc_ok), .zero_o(zero),
		.over_o(over), .dir_o(dir), .mismatch_o(mism), .plaus_err_o(plaus));
	ssm_sensor_model sens (.clk_i(clk_i), .rst_i(rst_i), .quarter_i(quarter), .ccw_i(ccw),
		.jump_i(jump), .enc_a_o(ea), .enc_b_o(eb), .prox_o(px));
	task automatic end_sim;
		if (err_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic flag(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask : flag
	// classic single cycle; read data taken at the edge that sees ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && k < 50)
		begin
			@(posedge clk_i);
			k++;
		end
		flag("wb_ack_o", 1'b1, ack);
		rd = rdat;
		cyc <= 1'b0;
	endtask : bus
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rdchk
	// set the axis speed, then let two whole gates pass
	task automatic run(input logic [7:0] q, input logic d);
		@(posedge clk_i);
		quarter <= q;
		ccw     <= d;
		repeat (2 * GATE + 20) @(posedge clk_i);
	endtask : run
	task automatic t_reset;
		flag("over_o", 1'b1, over);
		flag("zero_o", 1'b0, zero);
		rdchk("ctrl", OFS_CTRL, CTRL_RST);
		rdchk("res", OFS_RES, RES_RST);
		rdchk("ratio", OFS_RATIO, 32'(RATIO_RST));
		rdchk("thr8", OFS_THR + 8'h1c, 32'(THR_RST));
		rdchk("unmapped", 8'h40, 32'h0);
		bus(1'b1, OFS_FREQ1, 32'h0000_1234);
		rdchk("freq1", OFS_FREQ1, 32'h0);
		flag("plaus_err_o", 1'b0, plaus);
		flag("mismatch_o", 1'b0, mism);
		flag("dir_o", 1'b0, dir);
	endtask : t_reset
	task automatic t_zero;
		bus(1'b1, OFS_ZERO, 32'h5);
		run(8'h00, 1'b0);
		flag("zero_o", 1'b1, zero);
		run(8'h01, 1'b0);
		flag("zero_o", 1'b0, zero);
		rdchk("freq1", OFS_FREQ1, 32'h32);
	endtask : t_zero
	// threshold 30, 50 percent: lower frequency 15
	task automatic t_hyst;
		bus(1'b1, OFS_THR, 32'h1e);
		bus(1'b1, OFS_CTRL, 32'h32 << CTRL_HYST_LSB);
		run(8'h01, 1'b0);
		flag("over_o", 1'b0, over);
		run(8'h02, 1'b0);
		flag("over_o", 1'b0, over);
		run(8'h05, 1'b0);
		flag("over_o", 1'b1, over);
		bus(1'b1, OFS_CTRL, (32'h32 << CTRL_HYST_LSB) | (32'h1 << CTRL_POL));
		run(8'h05, 1'b0);
		flag("over_o", 1'b0, over);
		run(8'h01, 1'b0);
		flag("over_o", 1'b1, over);
	endtask : t_hyst
	task automatic t_dir;
		logic exc;
		for (int m = 0; m < 3; m++)
			for (int d = 0; d < 2; d++)
			begin
				exc = (m == 0) || (m == 1 && d == 0) || (m == 2 && d == 1);
				bus(1'b1, OFS_CTRL, (32'(m) << CTRL_MODE_LSB) | (32'h1 << CTRL_DIR_EN));
				run(8'h01, d[0]);
				flag("over_o", !exc, over);
				flag("dir_o", d[0], dir);
			end
		bus(1'b1, OFS_CTRL, 32'(CFG_PROX) | (32'h1 << CTRL_DIR_EN));
		run(8'h01, 1'b1);
		flag("dir_o", 1'b0, dir);
		flag("over_o", 1'b0, over);
	endtask : t_dir
	// only the selected slot holds a reachable threshold
	task automatic t_sel;
		bus(1'b1, OFS_THR, 32'hff_ffff);
		bus(1'b1, OFS_CTRL, 32'h3 << CTRL_THRN_LSB);
		for (int k = 0; k < 8; k++)
		begin
			bus(1'b1, OFS_THR + 8'(4 * k), 32'ha);
			tsel <= 3'(k);
			run(8'h01, 1'b0);
			flag("over_o", 1'b0, over);
			bus(1'b1, OFS_THR + 8'(4 * k), 32'hff_ffff);
		end
		run(8'h01, 1'b0);
		flag("over_o", 1'b1, over);
		bus(1'b1, OFS_THR, 32'ha);
		bus(1'b1, OFS_CTRL, (32'h3 << CTRL_THRN_LSB) | (32'h1 << CTRL_LEGACY));
		tsel <= 3'h4;
		run(8'h01, 1'b0);
		flag("over_o", 1'b0, over);
	endtask : t_sel
	// every two-sensor set; the last one also inverts the proximity inputs
	task automatic t_two;
		logic [2:0] sets [3];
		sets = '{CFG_ENC_ENC, CFG_ENC_PROX, CFG_PROX_PROX};
		for (int s = 0; s < 3; s++)
		begin
			bus(1'b1, OFS_RATIO, 32'h1);
			bus(1'b1, OFS_CTRL, 32'(sets[s]) | (32'(s == 2) << CTRL_PROX_INV));
			run(8'h01, 1'b0);
			flag("mismatch_o", 1'b0, mism);
			rdchk("freq2", OFS_FREQ2, 32'h32);
			bus(1'b1, OFS_RATIO, 32'h2);
			run(8'h01, 1'b0);
			flag("mismatch_o", 1'b1, mism);
		end
	endtask : t_two
	task automatic t_plaus;
		bus(1'b1, OFS_CTRL, 32'(CFG_ENC));
		sc_ok <= 1'b0;
		repeat (10) @(posedge clk_i);
		sc_ok <= 1'b1;
		repeat (10) @(posedge clk_i);
		flag("plaus_err_o", 1'b1, plaus);
		bus(1'b1, OFS_STATUS, 32'h10);
		repeat (4) @(posedge clk_i);
		flag("plaus_err_o", 1'b0, plaus);
		bus(1'b1, OFS_CTRL, 32'h1 << CTRL_ACHK_DIS);
		sc_ok <= 1'b0;
		run(8'h01, 1'b0);
		flag("plaus_err_o", 1'b0, plaus);
		jump <= 1'b1;
		run(8'h02, 1'b0);
		flag("plaus_err_o", 1'b1, plaus);
		jump  <= 1'b0;
		sc_ok <= 1'b1;
		repeat (10) @(posedge clk_i);
		bus(1'b1, OFS_STATUS, 32'h10);
		repeat (4) @(posedge clk_i);
		flag("plaus_err_o", 1'b0, plaus);
	endtask : t_plaus
	// reset in mid-run, with direction shown and registers written
	task automatic t_rst;
		bus(1'b1, OFS_CTRL, 32'(CFG_ENC_ENC) | (32'h1 << CTRL_DIR_EN));
		bus(1'b1, OFS_ZERO, 32'h7);
		run(8'h01, 1'b1);
		flag("dir_o", 1'b1, dir);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		flag("over_o", 1'b1, over);
		flag("dir_o", 1'b0, dir);
		repeat (8) @(posedge clk_i);
		flag("plaus_err_o", 1'b0, plaus);
		flag("dir_o", 1'b0, dir);
		rdchk("ctrl", OFS_CTRL, CTRL_RST);
		rdchk("zero", OFS_ZERO, 32'(ZERO_RST));
	endtask : t_rst
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_zero;
		t_hyst;
		t_dir;
		t_sel;
		t_two;
		t_plaus;
		t_rst;
		end_sim;
	end
	// about 14k clocks expected; a hang ends at 40k
	initial
	begin
		repeat (40000) @(posedge clk_i);
		err_count++;
		end_sim;
	end
endmodule : ssm_top_tb
`default_nettype wire
